// *** src/dmi_consts.svh ***
`ifndef DMI_CONSTS_SVH
`define DMI_CONSTS_SVH

// ==========================================================================
// register byte offsets
`define DMI_CFG_OFS          8'h00
`define DMI_LAMP_OFS         8'h04
`define DMI_STATUS_OFS       8'h08

// ==========================================================================
// field positions
`define DMI_CFG_ELECTRIC_BIT 0
`define DMI_CFG_SPEED_LSB    8
`define DMI_LAMP_DELAY_LSB   0
`define DMI_LAMP_DUR_LSB     16

// ==========================================================================
// reset values
`define DMI_CFG_RST          32'h0000_3200
`define DMI_LAMP_RST         32'h07D0_0064

// ==========================================================================
// timing
`define DMI_CLK_PERIOD_NS    10
`define DMI_MS_NS            1000000
`define DMI_FLASH_HALF_MS    16'h00C8

`endif

// *** src/dmi_pkg.sv ***
package dmi_pkg;
   // operator drive modes; the value is also the indicator bit index
   typedef enum logic [2:0] {
      DMI_M_2HI  = 3'h0,
      DMI_M_4HI  = 3'h1,
      DMI_M_4LO  = 3'h2,
      DMI_M_AUTO = 3'h3,
      DMI_M_AWD  = 3'h4,
      DMI_M_NEUT = 3'h5
   } dmi_mode_t;

   // lamp test sequencer states, one-hot
   typedef enum logic [3:0] {
      DMI_L_OFF   = 4'h1,
      DMI_L_DELAY = 4'h2,
      DMI_L_TEST  = 4'h4,
      DMI_L_RUN   = 4'h8
   } dmi_lamp_t;
endpackage : dmi_pkg

// *** src/dmi_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// loadable down counter, steps once per tick
module dmi_timer #(
   parameter int W = 16
) (
   input  wire logic         clk_in,     // system clock
   input  wire logic         rst_n_in,   // async reset, active low
   input  wire logic         load_in,    // load value, wins over tick
   input  wire logic [W-1:0] value_in,   // value to load
   input  wire logic         tick_in,    // count step
   output logic              done_out    // count has reached zero
);
   logic [W-1:0] count_reg;              // remaining ticks

   // count down, stop at zero
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_reg <= '0;
      end else if (load_in) begin
         count_reg <= value_in;
      end else if (tick_in && count_reg != '0) begin
         count_reg <= count_reg - W'(1);
      end
   end

   assign done_out = (count_reg == '0);
endmodule : dmi_timer
`default_nettype wire

// *** src/dmi_mode_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// switch position code to selected mode; bad codes keep the last mode
module dmi_mode_decode
   import dmi_pkg::*;
(
   input  wire logic       clk_in,    // system clock
   input  wire logic       rst_n_in,  // async reset, active low
   input  wire logic [2:0] code_in,   // synchronised switch code
   output dmi_mode_t       mode_out   // last valid selected mode
);
   dmi_mode_t mode_reg;               // held selection

   function automatic logic code_ok(input logic [2:0] c);
      code_ok = (c >= 3'h1) && (c <= 3'h6);
   endfunction : code_ok

   // open, short and gap codes leave the selection as it was
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_reg <= DMI_M_2HI;
      end else if (code_ok(code_in)) begin
         mode_reg <= dmi_mode_t'(code_in - 3'h1);
      end
   end

   assign mode_out = mode_reg;
endmodule : dmi_mode_decode
`default_nettype wire

// *** src/dmi_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "dmi_consts.svh"

module dmi_ctrl
   import dmi_pkg::*;
#(
   parameter int MS_CYCLES = `DMI_MS_NS / `DMI_CLK_PERIOD_NS  // clocks per millisecond
) (
   input  wire logic        sys_clk_in,        // 100 MHz system clock
   input  wire logic        reset_n_in,        // async reset, active low
   // ahb-lite slave
   input  wire logic        hsel_in,           // slave select
   input  wire logic [7:0]  haddr_in,          // byte address
   input  wire logic [1:0]  htrans_in,         // transfer type
   input  wire logic        hwrite_in,         // write when high
   input  wire logic [2:0]  hsize_in,          // transfer size
   input  wire logic [31:0] hwdata_in,         // write data
   input  wire logic        hready_in,         // bus ready
   output logic [31:0]      hrdata_out,        // read data
   output logic             hreadyout_out,     // slave ready
   output logic             hresp_out,         // always okay
   // pins
   input  wire logic [2:0]  mode_code_in,      // digitised switch position
   input  wire logic        case_4wd_in,       // transfer case in 4WD position
   input  wire logic        axle_engaged_in,   // secondary axle feedback
   input  wire logic        power_run_in,      // power mode is run
   // same-clock logic
   input  wire logic        antilock_active_in,// serial ABS active value
   input  wire logic        antilock_rx_in,    // pulse: ABS signal received
   input  wire logic [7:0]  vehicle_speed_in,  // speed in mph
   input  wire logic        shift_done_in,     // pulse: shift completed
   input  wire logic        neutral_ok_in,     // neutral enabling conditions met
   input  wire logic        front_axle_cmd_in, // engage front axle
   input  wire logic        diff_lock_cmd_in,  // engage diff lock
   input  wire logic        slip_req_in,       // slip correction wanted
   input  wire logic        adaptive_req_in,   // adaptive event wanted
   // outputs
   output logic             sec_axle_gnd_out,  // high closes switch to ground
   output logic             front_axle_n_out,  // low engages front axle
   output logic             diff_lock_out,     // high drives lock coil
   output logic [6:0]       led_on_out,        // indicator lit, bit 6 diff lock
   output logic             slip_en_out,       // slip correction allowed
   output logic             adaptive_en_out,   // adaptive events allowed
   output logic             antilock_hold_out  // in antilock response state
);
   // ==========================================================================
   // pin synchronisers, two stages, only stage two is read
   logic [5:0] pin_s1_reg;                     // first stage
   logic [5:0] pin_s2_reg;                     // second stage
   logic       power_prev_reg;                 // power run one clock ago

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pin_s1_reg     <= '0;
         pin_s2_reg     <= '0;
         power_prev_reg <= 1'b0;
      end else begin
         pin_s1_reg     <= {power_run_in, axle_engaged_in, case_4wd_in, mode_code_in};
         pin_s2_reg     <= pin_s1_reg;
         power_prev_reg <= pin_s2_reg[5];
      end
   end

   logic       power_s;                        // synchronised power run
   logic       axle_s;                         // synchronised axle feedback
   logic       case4_s;                        // synchronised 4WD position
   logic       power_rise;                     // off to run this clock
   assign power_s    = pin_s2_reg[5];
   assign axle_s     = pin_s2_reg[4];
   assign case4_s    = pin_s2_reg[3];
   assign power_rise = power_s && !power_prev_reg;

   // ==========================================================================
   // ahb-lite slave, zero wait: read data is registered in the address phase
   logic [31:0] cfg_reg;                       // system type, speed limit
   logic [31:0] lamp_reg;                      // lamp delay and duration, ms
   logic [31:0] hrdata_reg;                    // read data
   logic        wr_pend_reg;                   // write data phase pending
   logic [7:0]  wr_addr_reg;                   // write address
   logic [31:0] status;                        // live status word
   logic        addr_ph;                       // valid address phase

   assign addr_ph = hsel_in && hready_in && htrans_in[1];

   function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [31:0] c,
                                          input logic [31:0] l, input logic [31:0] s);
      if (a == `DMI_CFG_OFS) begin
         rd_mux = c;
      end else if (a == `DMI_LAMP_OFS) begin
         rd_mux = l;
      end else if (a == `DMI_STATUS_OFS) begin
         rd_mux = s;
      end else begin
         rd_mux = 32'h0000_0000;               // unmapped reads zero
      end
   endfunction : rd_mux

   // address phase capture and read data
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata_reg  <= 32'h0000_0000;
      end else if (hready_in) begin
         wr_pend_reg <= addr_ph && hwrite_in;
         wr_addr_reg <= haddr_in;
         if (addr_ph && !hwrite_in) begin
            hrdata_reg <= rd_mux(haddr_in, cfg_reg, lamp_reg, status);
         end
      end
   end

   // register writes in the data phase; status is read only
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cfg_reg  <= `DMI_CFG_RST;
         lamp_reg <= `DMI_LAMP_RST;
      end else if (wr_pend_reg) begin
         if (wr_addr_reg == `DMI_CFG_OFS) begin
            cfg_reg <= hwdata_in;
         end else if (wr_addr_reg == `DMI_LAMP_OFS) begin
            lamp_reg <= hwdata_in;
         end
      end
   end

   // ready is low in reset and rises on the first edge after it; no wait states ever
   logic hready_reg;                           // slave ready
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         hready_reg <= 1'b0;
      end else begin
         hready_reg <= 1'b1;
      end
   end

   assign hrdata_out    = hrdata_reg;
   assign hreadyout_out = hready_reg;          // registered, never stalls
   assign hresp_out     = 1'b0;

   logic       electric;                       // electric shift system
   logic [7:0] speed_limit;                    // antilock speed limit
   assign electric    = cfg_reg[`DMI_CFG_ELECTRIC_BIT];
   assign speed_limit = cfg_reg[`DMI_CFG_SPEED_LSB +: 8];

   // ==========================================================================
   // axle and lock drivers
   logic sec_reg;                              // secondary axle switch
   logic front_n_reg;                          // front axle, active low
   logic diff_reg;                             // diff lock high side

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sec_reg     <= 1'b0;
         front_n_reg <= 1'b1;
         diff_reg    <= 1'b0;
      end else begin
         sec_reg     <= !electric && case4_s;
         front_n_reg <= !(electric && front_axle_cmd_in);
         diff_reg    <= diff_lock_cmd_in;
      end
   end

   // ==========================================================================
   // antilock response state
   dmi_mode_t sel_mode;                        // decoded selection
   dmi_mode_t cur_mode_reg;                    // mode after last shift
   logic      hold_reg;                        // antilock response active
   logic      abs_seen_reg;                    // ABS signal seen this ignition
   logic      hold_enter;                      // all four entry terms
   logic      hold_leave;                      // any re-enabling term
   logic      abs_fresh;                       // ABS value received this ignition

   // the serial link delivers ABS status; we only trust it once received.
   // the received flag still shows the old ignition in the rise clock, so mask it
   assign abs_fresh  = antilock_rx_in || (abs_seen_reg && !power_rise);
   assign hold_enter = (cur_mode_reg == DMI_M_AWD) && (vehicle_speed_in > speed_limit)
                       && antilock_active_in && abs_fresh;
   assign hold_leave = !antilock_active_in || (vehicle_speed_in < speed_limit)
                       || !abs_fresh;

   // leaving takes one clock, well inside the 500 ms allowance
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         hold_reg <= 1'b0;
      end else if (hold_reg) begin
         hold_reg <= !hold_leave;
      end else begin
         hold_reg <= hold_enter;
      end
   end

   // received flag restarts with each ignition cycle; a receipt wins
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         abs_seen_reg <= 1'b0;
      end else if (antilock_rx_in) begin
         abs_seen_reg <= 1'b1;
      end else if (power_rise) begin
         abs_seen_reg <= 1'b0;
      end
   end

   // slip and adaptive gating; entry cuts both in the same clock
   logic slip_reg;                             // slip correction allowed
   logic adapt_reg;                            // adaptive events allowed
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         slip_reg  <= 1'b0;
         adapt_reg <= 1'b0;
      end else begin
         slip_reg  <= slip_req_in && !hold_reg && !hold_enter;
         adapt_reg <= adaptive_req_in && !hold_reg && !hold_enter;
      end
   end

   // ==========================================================================
   // mode selection and shift tracking
   dmi_mode_t prev_mode_reg;                   // mode before pending shift
   logic      shifting_reg;                    // new mode selected, not shifted

   dmi_mode_decode u_decode (
      .clk_in   (sys_clk_in),
      .rst_n_in (reset_n_in),
      .code_in  (pin_s2_reg[2:0]),
      .mode_out (sel_mode)
   );

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cur_mode_reg  <= DMI_M_2HI;
         prev_mode_reg <= DMI_M_2HI;
         shifting_reg  <= 1'b0;
      end else if (sel_mode != cur_mode_reg && !shifting_reg) begin
         prev_mode_reg <= cur_mode_reg;
         shifting_reg  <= 1'b1;
      end else if (shifting_reg && shift_done_in) begin
         cur_mode_reg  <= sel_mode;
         shifting_reg  <= 1'b0;
      end
   end

   // ==========================================================================
   // millisecond tick and flash timebase
   logic [$clog2(MS_CYCLES)-1:0] pre_reg;      // ms prescaler
   logic ms_tick;                              // one clock per ms
   logic flash_done;                           // half period elapsed
   logic flash_reg;                            // flash phase
   logic flash_step;                           // ms tick that ends a half period
   assign ms_tick = (pre_reg == '0);
   // reload only on a tick: done alone would reload in the clock after the zero tick, so each half period would be one tick short
   assign flash_step = flash_done && ms_tick;

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pre_reg <= '0;
      end else if (ms_tick) begin
         pre_reg <= ($clog2(MS_CYCLES))'(MS_CYCLES - 1);
      end else begin
         pre_reg <= pre_reg - 1'b1;
      end
   end

   // 200 ms half period gives 2.5 Hz
   dmi_timer #(.W(16)) u_flash (
      .clk_in   (sys_clk_in),
      .rst_n_in (reset_n_in),
      .load_in  (flash_step),
      .value_in (`DMI_FLASH_HALF_MS - 16'h0001),
      .tick_in  (ms_tick),
      .done_out (flash_done)
   );

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         flash_reg <= 1'b0;
      end else if (flash_step) begin
         flash_reg <= !flash_reg;
      end
   end

   // ==========================================================================
   // lamp test sequencer
   dmi_lamp_t lamp_reg_st;                     // sequencer state
   logic      lamp_load;                       // reload lamp timer
   logic [15:0] lamp_val;                      // value to reload
   logic      lamp_done;                       // lamp timer expired

   always_comb begin
      lamp_load = 1'b0;
      lamp_val  = lamp_reg[`DMI_LAMP_DELAY_LSB +: 16];
      if (power_rise) begin
         lamp_load = 1'b1;
      end else if (lamp_reg_st == DMI_L_DELAY && lamp_done) begin
         lamp_load = 1'b1;
         lamp_val  = lamp_reg[`DMI_LAMP_DUR_LSB +: 16];
      end
   end

   dmi_timer #(.W(16)) u_lamp (
      .clk_in   (sys_clk_in),
      .rst_n_in (reset_n_in),
      .load_in  (lamp_load),
      .value_in (lamp_val),
      .tick_in  (ms_tick),
      .done_out (lamp_done)
   );

   // a fresh off to run restarts the test from any state
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         lamp_reg_st <= DMI_L_OFF;
      end else if (!power_s) begin
         lamp_reg_st <= DMI_L_OFF;
      end else if (power_rise) begin
         lamp_reg_st <= DMI_L_DELAY;
      end else begin
         case (lamp_reg_st)
            DMI_L_DELAY: if (lamp_done) lamp_reg_st <= DMI_L_TEST;
            DMI_L_TEST:  if (lamp_done) lamp_reg_st <= DMI_L_RUN;
            default:     lamp_reg_st <= lamp_reg_st;
         endcase
      end
   end

   // ==========================================================================
   // indicator outputs
   logic [6:0] led_reg;                        // lit indicators
   logic [6:0] led_next;                       // next indicators
   logic       needs_axle;                     // current mode needs axle

   assign needs_axle = (cur_mode_reg == DMI_M_4HI) || (cur_mode_reg == DMI_M_4LO)
                       || (cur_mode_reg == DMI_M_AWD);

   always_comb begin
      led_next = 7'h00;
      if (lamp_reg_st == DMI_L_TEST) begin
         led_next = 7'h7F;
      end else if (lamp_reg_st == DMI_L_RUN) begin
         if (shifting_reg) begin
            led_next[prev_mode_reg] = 1'b1;
            if (sel_mode != DMI_M_NEUT || neutral_ok_in) begin
               led_next[sel_mode] = flash_reg;
            end
         end else if (needs_axle && !axle_s) begin
            led_next[cur_mode_reg] = flash_reg;
            led_next[DMI_M_2HI]    = 1'b1;
         end else begin
            led_next[cur_mode_reg] = 1'b1;
         end
         led_next[6] = diff_reg;
      end
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         led_reg <= 7'h00;
      end else begin
         led_reg <= led_next;
      end
   end

   assign status = {16'h0000, lamp_reg_st == DMI_L_TEST, led_reg,
                    shifting_reg, hold_reg, cur_mode_reg, sel_mode};

   assign sec_axle_gnd_out  = sec_reg;
   assign front_axle_n_out  = front_n_reg;
   assign diff_lock_out     = diff_reg;
   assign led_on_out        = led_reg;
   assign slip_en_out       = slip_reg;
   assign adaptive_en_out   = adapt_reg;
   assign antilock_hold_out = hold_reg;

   // ==========================================================================
   // assertions
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);

   AST_SEC_AXLE: assert property (!electric && case4_s |=> sec_axle_gnd_out)
      else $error("axle switch open");
   AST_FRONT: assert property (electric && front_axle_cmd_in |=> !front_axle_n_out)
      else $error("front not low");
   AST_DIFF: assert property (diff_lock_cmd_in |=> diff_lock_out) else $error("diff lock not driven");
   AST_ENTER: assert property (hold_enter && !hold_reg |=> antilock_hold_out)
      else $error("hold not entered");
   AST_ENTER_CAUSE: assert property ($rose(hold_reg) |-> $past(vehicle_speed_in) > $past(speed_limit))
      else $error("hold without speed");
   AST_SLIP: assert property (antilock_hold_out |-> !slip_en_out) else $error("slip during hold");
   AST_ADAPT: assert property (hold_reg |=> !adaptive_en_out) else $error("adaptive during hold");
   AST_LEAVE: assert property (hold_reg && !antilock_active_in |=> !hold_reg) else $error("hold not left");
   AST_IGN: assert property (hold_reg && power_rise && !antilock_rx_in |=> !hold_reg)
      else $error("hold kept over new ignition");
   AST_LAMP: assert property (lamp_reg_st == DMI_L_TEST |=> led_on_out == 7'h7F)
      else $error("lamp test dark");
   AST_NEUT: assert property (lamp_reg_st == DMI_L_RUN && shifting_reg && sel_mode == DMI_M_NEUT
                              && !neutral_ok_in && prev_mode_reg != DMI_M_NEUT |=> !led_on_out[DMI_M_NEUT])
      else $error("neutral lit");

   COV_HOLD: cover property (hold_reg ##1 !hold_reg);
   COV_LAMP: cover property (lamp_reg_st == DMI_L_TEST ##1 lamp_reg_st == DMI_L_RUN);
   COV_SHIFT: cover property (shifting_reg && shift_done_in);
endmodule : dmi_ctrl
`default_nettype wire

// *** verification/dmi_plat_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// platform side: serial antilock report, speed and switch code
module dmi_plat_model (
   input  wire logic       clk_in,      // system clock
   input  wire logic       rst_n_in,    // async reset, active low
   input  wire logic       abs_set_in,  // antilock value to report
   input  wire logic [7:0] spd_set_in,  // speed to report
   input  wire logic [2:0] code_set_in, // switch position
   output logic            abs_out,     // received antilock value
   output logic            rx_out,      // pulse per report
   output logic [7:0]      spd_out,     // received speed
   output logic [2:0]      code_out     // switch code pin
);
   // reports on change only, so a stale value is never re-announced
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         abs_out  <= 1'b0;
         rx_out   <= 1'b0;
         spd_out  <= 8'h00;
         code_out <= 3'h0;
      end else begin
         rx_out   <= (abs_set_in != abs_out);
         abs_out  <= abs_set_in;
         spd_out  <= spd_set_in;
         code_out <= code_set_in;
      end
   end
endmodule : dmi_plat_model
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hrdy, abs, rx;
   logic        case4 = 0, axle = 0, pwr = 0, sdone = 0, nok = 0, fcmd = 0, dcmd = 0, abs_s = 0;
   logic        sgnd, fan, dl, slip, adap, hold, hrsp;
   logic [7:0]  haddr = 0, spd_s = 0, spd;
   logic [1:0]  htrans = 0;
   logic [2:0]  code_s = 0, code;
   logic [6:0]  led;
   logic [31:0] hwdata = 0, hrdata, r;
   int          fails = 0, num_checks = 0, n;
   always #5 clk = ~clk;
   // ==========================================
   // design and platform model
   dmi_ctrl #(.MS_CYCLES(10)) dut_u (.sys_clk_in(clk), .reset_n_in(rst_n), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
      .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
      .hresp_out(hrsp), .mode_code_in(code), .case_4wd_in(case4), .axle_engaged_in(axle),
      .power_run_in(pwr), .antilock_active_in(abs), .antilock_rx_in(rx), .vehicle_speed_in(spd),
      .shift_done_in(sdone), .neutral_ok_in(nok), .front_axle_cmd_in(fcmd),
      .diff_lock_cmd_in(dcmd), .slip_req_in(1'b1), .adaptive_req_in(1'b1),
      .sec_axle_gnd_out(sgnd), .front_axle_n_out(fan), .diff_lock_out(dl), .led_on_out(led),
      .slip_en_out(slip), .adaptive_en_out(adap), .antilock_hold_out(hold));
   dmi_plat_model model_u (.clk_in(clk), .rst_n_in(rst_n), .abs_set_in(abs_s), .spd_set_in(spd_s),
      .code_set_in(code_s), .abs_out(abs), .rx_out(rx), .spd_out(spd), .code_out(code));
   // ==========================================
   // helpers
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1; htrans <= 2'h2; haddr <= a; hwrite <= w;
      @(posedge clk);
      while (!hrdy) @(posedge clk);
      hsel <= 0; htrans <= 2'h0; hwdata <= d;
      @(posedge clk);
      while (!hrdy) @(posedge clk);
      r = hrdata;
   endtask : bus
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         $display("CHECK FAILED %s exp %h got %h", nm, e, s);
         fails++;
      end
   endtask : chk
   // settle past the edge before looking
   task automatic wn(input int c);
      repeat (c) @(posedge clk);
      @(negedge clk);
   endtask : wn
   // cycles until led bit i changes, capped
   task automatic tgl(input int i, output int c);
      logic v;
      v = led[i];
      c = 0;
      while (led[i] === v && c < 3000) begin
         @(negedge clk);
         c++;
      end
   endtask : tgl
   task automatic sel(input logic [2:0] c, input logic sh);
      @(posedge clk) code_s <= c;
      wn(6);
      if (sh) begin
         @(posedge clk) sdone <= 1;
         @(posedge clk) sdone <= 0;
         wn(3);
      end
   endtask : sel
   task automatic finish_test();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   // ==========================================
   // tests; about 12000 cycles, so 60000 means a hang
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      finish_test();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1;
      bus(0, 8'h00, 0); chk("cfg_rst", 32'h0000_3200, r);
      bus(0, 8'h04, 0); chk("lamp_rst", 32'h07D0_0064, r);
      bus(0, 8'h0C, 0); chk("unmapped", 0, r);
      chk("hresp", 0, hrsp);
      bus(1, 8'h00, 32'h0000_2000);
      bus(1, 8'h04, 32'h0005_0002);
      bus(0, 8'h04, 0); chk("lamp_cfg", 32'h0005_0002, r);
      @(posedge clk) case4 <= 1;
      wn(5); chk("axle_gnd", 1, sgnd);
      @(posedge clk) case4 <= 0;
      wn(5); chk("axle_rel", 0, sgnd);
      bus(1, 8'h00, 32'h0000_2001);
      @(posedge clk) {fcmd, dcmd} <= 2'h3;
      wn(3); chk("front_on", 0, fan);
      chk("lock_on", 1, dl);
      @(posedge clk) {fcmd, dcmd} <= 2'h0;
      wn(3); chk("front_off", 1, fan);
      chk("lock_off", 0, dl);
      // lamp test: 2 ms delay then 5 ms lit
      @(posedge clk) pwr <= 1;
      wn(10); chk("lamp_wait", 0, led);
      wn(40); chk("lamp_on", 7'h7F, led);
      wn(45); chk("lamp_end", 0, led == 7'h7F);
      sel(4, 1);
      bus(0, 8'h08, 0); chk("auto_mode", 3, r[5:3]);
      sel(2, 0);
      tgl(1, n);
      tgl(1, n); chk("half_period", 1, n >= 1667 && n <= 2500);
      // axle mode shifted with the axle still open: flash plus 2HI lit
      sel(5, 1);
      tgl(4, n);
      tgl(4, n); chk("awd_flash", 1, n >= 1667 && n <= 2500);
      chk("awd_2hi", 1, led[0]);
      @(posedge clk) axle <= 1;
      wn(5);
      bus(0, 8'h08, 0); chk("sel_mode", 4, r[2:0]);
      chk("prev_off", 0, led[3]);
      chk("awd_solid", 1, led[4]);
      // antilock hold: speed at the limit is not above it
      @(posedge clk) {abs_s, spd_s} <= {1'b1, 8'h20};
      wn(5); chk("hold_at_limit", 0, hold);
      @(posedge clk) spd_s <= 8'h21;
      wn(4); chk("hold_in", 1, hold);
      chk("slip_off", 0, slip);
      chk("adapt_off", 0, adap);
      @(posedge clk) abs_s <= 0;
      wn(4); chk("hold_abs_out", 0, hold);
      chk("adapt_back", 1, adap);
      @(posedge clk) abs_s <= 1;
      wn(4); chk("hold_again", 1, hold);
      // new ignition with no fresh report ends the hold; wait out the lamp test
      @(posedge clk) pwr <= 0;
      wn(4);
      @(posedge clk) pwr <= 1;
      wn(6); chk("hold_ign_out", 0, hold);
      wn(80);
      @(posedge clk) abs_s <= 0;
      wn(2);
      @(posedge clk) abs_s <= 1;
      wn(4); chk("hold_rx_in", 1, hold);
      @(posedge clk) spd_s <= 8'h1F;
      wn(4); chk("hold_slow_out", 0, hold);
      // neutral stays dark until enabled
      @(posedge clk) abs_s <= 0;
      sel(6, 0);
      n = 0;
      repeat (2500) begin
         @(negedge clk);
         if (led[5] !== 1'b0) n++;
      end
      chk("neut_dark", 0, n);
      @(posedge clk) nok <= 1;
      tgl(5, n); chk("neut_flash", 1, n < 2100);
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
